/* File: hw/ccfc_pkg.sv */
// package: instruction classes, flag layout and constants for cycle and flag control
// assumes an outside decoder that maps every opcode onto one class below
package ccfc_pkg;
   localparam int         PC_W          = 10;
   localparam int         STACK_W       = 16;
   localparam logic [7:0] BIT_ADDR_MAX  = 8'h3f;
   localparam logic [7:0] SP_STEP       = 8'h02;
   localparam logic [7:0] SP_RESET      = 8'h00;
   localparam logic [3:0] MASK_NONE     = 4'h0;
   localparam logic [3:0] MASK_ALL      = 4'hf;
   localparam logic [3:0] MASK_Z        = 4'h8;
   localparam logic [3:0] MASK_C        = 4'h4;

   typedef enum logic [4:0] {
      CL_MOV_NF, CL_MOV_Z, CL_IDXM, CL_TIMER_WORD_LOAD, CL_TIMER_WORD_STORE, CL_XCH,
      CL_PUSHAF, CL_POPAF, CL_ARITH, CL_CLEAR, CL_SHIFT, CL_LOGIC, CL_COMPL,
      CL_BIT_IO, CL_BIT_SET_MEM, CL_BIT_CLR_MEM, CL_CMP_SKIP, CL_TEST_IO, CL_TEST_MEM,
      CL_INCDEC_SKIP, CL_COMPARE, CL_NADD, CL_SWAPC, CL_GOTO, CL_CALL, CL_RET,
      CL_RETI, CL_PCADD, CL_ENGINT, CL_DISGINT, CL_SYSCTL
   } ccfc_class_t;

   typedef struct packed {
      logic z;
      logic c;
      logic ac;
      logic ov;
   } ccfc_flags_t;

   typedef struct packed {
      ccfc_class_t       cls;
      logic              skipCond;
      logic [7:0]        bitAddr;
      ccfc_flags_t       aluFlags;
      logic [7:0]        accIn;
      logic [PC_W-1:0]   pcNext;
      logic [PC_W-1:0]   pcTarget;
   } ccfc_req_t;

   typedef enum {ST_FIRST, ST_SECOND} ccfc_state_t;
endpackage : ccfc_pkg

/* File: hw/ccfc_core.sv */
// cycle timing, flag update, bit-range check, stack and interrupt-enable control
// assumes the decoder holds req stable while instValid is high and instReady is low
`timescale 1ns/1ps
module ccfc_core
   import ccfc_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             instValid,
   input  wire ccfc_req_t        req,
   output      logic             instReady,
   output      logic             instDone,
   output      logic             skipNext,
   output      logic             writeBack,
   output      logic             bitReject,
   output      ccfc_flags_t      flags,
   output      logic             gie,
   output      logic             pcLoad,
   output      logic [PC_W-1:0]  pcOut,
   output      logic             accLoad,
   output      logic [7:0]       accOut,
   output      logic [7:0]       sp
);
   localparam int IDX_W = $clog2(STACK_DEPTH);

   if (STACK_DEPTH < 2 || STACK_DEPTH > 128 || (1 << IDX_W) != STACK_DEPTH) begin : g_bad_depth
      $error("STACK_DEPTH must be a power of two from 2 to 128");
   end

   // which flags a class writes from the alu
   function automatic logic [3:0] flagMask(ccfc_class_t c);
      case (c)
         CL_ARITH, CL_INCDEC_SKIP:         flagMask = MASK_ALL;
         CL_CMP_SKIP:                      flagMask = MASK_ALL;
         CL_COMPARE, CL_NADD:              flagMask = MASK_ALL;
         CL_SHIFT:                         flagMask = MASK_C;
         CL_SWAPC:                         flagMask = MASK_C;
         CL_LOGIC, CL_COMPL, CL_MOV_Z:     flagMask = MASK_Z;
         CL_TEST_IO, CL_TEST_MEM:          flagMask = MASK_NONE;
         default:                          flagMask = MASK_NONE;
      endcase
   endfunction : flagMask

   function automatic logic fixedTwo(ccfc_class_t c);
      fixedTwo = c inside {CL_GOTO, CL_CALL, CL_IDXM, CL_PCADD, CL_RET, CL_RETI};
   endfunction : fixedTwo

   function automatic logic isSkip(ccfc_class_t c);
      isSkip = c inside {CL_CMP_SKIP, CL_TEST_IO, CL_TEST_MEM, CL_INCDEC_SKIP};
   endfunction : isSkip

   function automatic logic isBitMem(ccfc_class_t c);
      isBitMem = c inside {CL_BIT_SET_MEM, CL_BIT_CLR_MEM, CL_TEST_MEM};
   endfunction : isBitMem

   // compares and tests produce no result
   function automatic logic writesResult(ccfc_class_t c);
      writesResult = c inside {CL_MOV_NF, CL_MOV_Z, CL_IDXM, CL_TIMER_WORD_LOAD,
                               CL_TIMER_WORD_STORE, CL_XCH, CL_ARITH, CL_CLEAR, CL_SHIFT,
                               CL_LOGIC, CL_COMPL, CL_BIT_IO, CL_BIT_SET_MEM,
                               CL_BIT_CLR_MEM, CL_INCDEC_SKIP, CL_NADD, CL_SWAPC};
   endfunction : writesResult

   function automatic logic [IDX_W-1:0] slot(logic [7:0] a);
      slot = a[IDX_W:1];
   endfunction : slot

   function automatic ccfc_flags_t mergeFlags(ccfc_flags_t old, ccfc_flags_t alu,
                                              logic [3:0] m);
      mergeFlags = ccfc_flags_t'((old & ~m) | (alu & m));
   endfunction : mergeFlags

   ccfc_state_t        state;
   logic [STACK_W-1:0] stackMem [STACK_DEPTH];
   logic               accept;
   logic               bitOk;
   logic               takeSkip;
   logic               twoCycle;
   logic [7:0]         spDown;

   assign accept   = instValid && instReady;
   assign bitOk    = !isBitMem(req.cls) || (req.bitAddr <= BIT_ADDR_MAX);
   assign takeSkip = isSkip(req.cls) && req.skipCond && bitOk;
   assign twoCycle = fixedTwo(req.cls) || takeSkip;
   assign spDown   = sp - SP_STEP;

   // instruction timing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state     <= ST_FIRST;
         instReady <= 1'b1;
         instDone  <= 1'b0;
      end else begin
         case (state)
            ST_FIRST: begin
               instDone <= accept && !twoCycle;
               if (accept && twoCycle) begin
                  state     <= ST_SECOND;
                  instReady <= 1'b0;
               end
            end
            ST_SECOND: begin
               state     <= ST_FIRST;
               instReady <= 1'b1;
               instDone  <= 1'b1;
            end
            default: begin
               state     <= ST_FIRST;
               instReady <= 1'b1;
               instDone  <= 1'b0;
            end
         endcase
      end
   end

   // per-instruction side pulses
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         skipNext  <= 1'b0;
         writeBack <= 1'b0;
         bitReject <= 1'b0;
      end else begin
         skipNext  <= accept && takeSkip;
         writeBack <= accept && bitOk && writesResult(req.cls);
         bitReject <= accept && !bitOk;
      end
   end

   // flag register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         flags <= ccfc_flags_t'(MASK_NONE);
      end else if (accept) begin
         if (req.cls == CL_POPAF) begin
            flags <= ccfc_flags_t'(stackMem[slot(spDown)][11:8]);
         end else begin
            flags <= mergeFlags(flags, req.aluFlags, flagMask(req.cls));
         end
      end
   end

   // global interrupt enable
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gie <= 1'b0;
      end else if (accept) begin
         if (req.cls == CL_ENGINT || req.cls == CL_RETI) begin
            gie <= 1'b1;
         end else if (req.cls == CL_DISGINT) begin
            gie <= 1'b0;
         end
      end
   end

   // stack pointer and stack words
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sp <= SP_RESET;
      end else if (accept) begin
         case (req.cls)
            CL_CALL: begin
               stackMem[slot(sp)] <= STACK_W'(req.pcNext);
               sp                 <= sp + SP_STEP;
            end
            CL_PUSHAF: begin
               stackMem[slot(sp)] <= STACK_W'({flags, req.accIn});
               sp                 <= sp + SP_STEP;
            end
            CL_RET, CL_RETI, CL_POPAF: begin
               sp <= spDown;
            end
            default: begin
               sp <= sp;
            end
         endcase
      end
   end

   // program counter and accumulator loads
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pcLoad  <= 1'b0;
         pcOut   <= '0;
         accLoad <= 1'b0;
         accOut  <= 8'h00;
      end else begin
         pcLoad  <= accept && (req.cls inside {CL_GOTO, CL_CALL, CL_PCADD, CL_RET, CL_RETI});
         accLoad <= accept && (req.cls == CL_POPAF);
         if (accept) begin
            case (req.cls)
               CL_GOTO, CL_CALL, CL_PCADD: pcOut  <= req.pcTarget;
               CL_RET, CL_RETI:            pcOut  <= stackMem[slot(spDown)][PC_W-1:0];
               CL_POPAF:                   accOut <= stackMem[slot(spDown)][7:0];
               default:                    pcOut  <= pcOut;
            endcase
         end
      end
   end

   AST_FIXED_TWO_CYCLE: assert property (@(posedge clk_sys) disable iff (reset)
      accept && fixedTwo(req.cls) |=> !instReady && !instDone ##1 instDone && instReady)
      else $error("two-cycle instruction did not take two cycles");

   AST_SKIP_TAKEN: assert property (@(posedge clk_sys) disable iff (reset)
      accept && takeSkip |=> skipNext && !instDone ##1 instDone)
      else $error("taken skip not two cycles with skip");

   AST_SKIP_NOT_TAKEN: assert property (@(posedge clk_sys) disable iff (reset)
      accept && isSkip(req.cls) && !takeSkip |=> instDone && !skipNext && instReady)
      else $error("untaken skip not one cycle");

   AST_OTHERS_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (reset)
      accept && !fixedTwo(req.cls) && !isSkip(req.cls) |=> instDone && instReady)
      else $error("plain instruction not one cycle");

   AST_FLAGS_KEPT: assert property (@(posedge clk_sys) disable iff (reset)
      accept && flagMask(req.cls) == MASK_NONE && req.cls != CL_POPAF |=> $stable(flags))
      else $error("flags changed on flag-neutral instruction");

   AST_FLAGS_ALL: assert property (@(posedge clk_sys) disable iff (reset)
      accept && flagMask(req.cls) == MASK_ALL |=> flags == $past(req.aluFlags))
      else $error("full flag update missing");

   AST_CARRY_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
      accept && req.cls inside {CL_SHIFT, CL_SWAPC} |=> flags.c == $past(req.aluFlags.c)
         && flags.z == $past(flags.z) && flags.ac == $past(flags.ac)
         && flags.ov == $past(flags.ov))
      else $error("carry-only update wrong");

   AST_ZERO_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
      accept && req.cls inside {CL_LOGIC, CL_COMPL} |=> flags.z == $past(req.aluFlags.z)
         && flags.c == $past(flags.c) && flags.ac == $past(flags.ac)
         && flags.ov == $past(flags.ov))
      else $error("zero-only update wrong");

   AST_BIT_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
      accept && isBitMem(req.cls) && req.bitAddr > BIT_ADDR_MAX
         |=> bitReject && !writeBack && !skipNext && instDone)
      else $error("out-of-range bit access not rejected");

   AST_SAVE_RESTORE: assert property (@(posedge clk_sys) disable iff (reset)
      (accept && req.cls == CL_PUSHAF) ##1 (accept && req.cls == CL_POPAF)
         |=> accLoad && accOut == $past(req.accIn, 2) && flags == $past(flags, 2))
      else $error("restore did not return saved accumulator and flags");

   AST_RETI_GIE: assert property (@(posedge clk_sys) disable iff (reset)
      accept && req.cls == CL_RETI |=> gie && pcLoad)
      else $error("interrupt return left global enable clear");

   AST_CALL_RET_SP: assert property (@(posedge clk_sys) disable iff (reset)
      (accept && req.cls == CL_CALL) ##2 (accept && req.cls == CL_RET)
         |=> sp == $past(sp, 3) && pcOut == $past(req.pcNext, 3))
      else $error("call and return did not pair on stack");

   AST_COMPARE_NO_WB: assert property (@(posedge clk_sys) disable iff (reset)
      accept && req.cls inside {CL_COMPARE, CL_CMP_SKIP} |=> !writeBack)
      else $error("compare wrote a result back");
endmodule : ccfc_core

/* File: verification/ccfc_prog_model.sv */
// instruction source model standing in for the decoder in front of the core
// assumes the core samples instValid and req on the rising edge of clk_sys
`timescale 1ns/1ps
module ccfc_prog_model
   import ccfc_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic instReady,
   input  wire logic instDone,
   input  wire logic skipNext,
   input  wire logic bitReject,
   input  wire logic writeBack,
   input  wire logic pcLoad,
   input  wire logic accLoad,
   output      logic instValid,
   output      ccfc_req_t req
);
   initial begin
      instValid = 1'b0;
      req       = '0;
   end

   // holds the offer until taken, then counts cycles up to the done pulse
   task automatic issue(input ccfc_req_t r, output int cyc, output logic sk, output logic rj,
                        output logic wb, output logic pl, output logic al);
      int guard;
      @(negedge clk_sys);
      instValid = 1'b1;
      req       = r;
      guard     = 0;
      while (instReady !== 1'b1 && guard < 8) begin
         @(negedge clk_sys);
         guard++;
      end
      @(negedge clk_sys);
      instValid = 1'b0;
      // released lines show the inverse, not the last value
      req       = ccfc_req_t'(~r);
      sk        = skipNext;
      rj        = bitReject;
      wb        = writeBack;
      pl        = pcLoad;
      al        = accLoad;
      cyc       = 1;
      while (instDone !== 1'b1 && cyc < 4) begin
         @(negedge clk_sys);
         cyc++;
      end
   endtask : issue

   // offers r2 right behind r1 so both are taken at the earliest legal edges
   task automatic issue_pair(input ccfc_req_t r1, input ccfc_req_t r2, output int gap);
      int guard;
      @(negedge clk_sys);
      instValid = 1'b1;
      req       = r1;
      guard     = 0;
      while (instReady !== 1'b1 && guard < 8) begin
         @(negedge clk_sys);
         guard++;
      end
      @(negedge clk_sys);
      req       = r2;
      gap       = 1;
      while (instReady !== 1'b1 && gap < 8) begin
         @(negedge clk_sys);
         gap++;
      end
      @(negedge clk_sys);
      instValid = 1'b0;
      req       = ccfc_req_t'(~r2);
      guard     = 0;
      while (instDone !== 1'b1 && guard < 8) begin
         @(negedge clk_sys);
         guard++;
      end
   endtask : issue_pair
endmodule : ccfc_prog_model

/* File: verification/test_cpu_cycle_and_flag_control.sv */
// self-checking bench for cycle timing, flag masking, bit range, stack and gie
// assumes ccfc_core with default stack depth, clocked at 40 MHz
`timescale 1ns/1ps
module test_cpu_cycle_and_flag_control;
   import ccfc_pkg::*;
   logic            clk_sys, reset, instValid, instReady, instDone, skipNext;
   logic            writeBack, bitReject, gie, pcLoad, accLoad, skSeen, rjSeen;
   logic            wbSeen, plSeen, alSeen;
   ccfc_req_t       req;
   ccfc_flags_t     flags;
   logic [PC_W-1:0] pcOut, pcN, pcT;
   logic [7:0]      accOut, sp, accV;
   logic [3:0]      expF, af, m;
   int              fails, cmpCount, cyc;
   ccfc_class_t     c;

   ccfc_core dut_u (.clk_sys(clk_sys), .reset(reset), .instValid(instValid), .req(req),
      .instReady(instReady), .instDone(instDone), .skipNext(skipNext), .writeBack(writeBack),
      .bitReject(bitReject), .flags(flags), .gie(gie), .pcLoad(pcLoad), .pcOut(pcOut),
      .accLoad(accLoad), .accOut(accOut), .sp(sp));
   ccfc_prog_model partner_u (.clk_sys(clk_sys), .instReady(instReady), .instDone(instDone),
      .skipNext(skipNext), .bitReject(bitReject), .writeBack(writeBack), .pcLoad(pcLoad),
      .accLoad(accLoad), .instValid(instValid), .req(req));

   always #12.5 clk_sys = ~clk_sys;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic run(input ccfc_class_t k, input logic s, input logic [7:0] ba,
                      input logic [3:0] f);
      ccfc_req_t r;
      r          = '0;
      r.cls      = k;
      r.skipCond = s;
      r.bitAddr  = ba;
      r.aluFlags = f;
      r.accIn    = accV;
      r.pcNext   = pcN;
      r.pcTarget = pcT;
      partner_u.issue(r, cyc, skSeen, rjSeen, wbSeen, plSeen, alSeen);
   endtask : run

   function automatic logic [3:0] maskOf(input ccfc_class_t k);
      case (k)
         CL_MOV_Z, CL_LOGIC, CL_COMPL: return 4'h8;
         CL_SHIFT, CL_SWAPC: return 4'h4;
         CL_ARITH, CL_CMP_SKIP, CL_INCDEC_SKIP, CL_COMPARE, CL_NADD: return 4'hf;
         default: return 4'h0;
      endcase
   endfunction : maskOf

   task automatic test_stack();
      pcN = 10'h0a3;
      pcT = 10'h155;
      run(CL_CALL, 1'b0, 8'h00, 4'h0);
      check("call pc", pcOut, 10'h155);
      check("call pc load", plSeen, 1'b1);
      check("call sp", sp, 8'h02);
      pcN = 10'h0b7;
      pcT = 10'h2aa;
      run(CL_CALL, 1'b0, 8'h00, 4'h0);
      check("nested sp", sp, 8'h04);
      run(CL_RET, 1'b0, 8'h00, 4'h0);
      check("ret pc", pcOut, 10'h0b7);
      run(CL_RET, 1'b0, 8'h00, 4'h0);
      check("ret pc2", pcOut, 10'h0a3);
      check("ret sp", sp, 8'h00);
      $display("test stack done");
   endtask : test_stack

   task automatic test_gie();
      run(CL_ENGINT, 1'b0, 8'h00, 4'h0);
      check("gie on", gie, 1'b1);
      run(CL_DISGINT, 1'b0, 8'h00, 4'h0);
      check("gie off", gie, 1'b0);
      pcN = 10'h311;
      run(CL_CALL, 1'b0, 8'h00, 4'h0);
      run(CL_RETI, 1'b0, 8'h00, 4'h0);
      check("reti gie", gie, 1'b1);
      check("reti pc", pcOut, 10'h311);
      $display("test gie done");
   endtask : test_gie

   task automatic test_save();
      run(CL_ARITH, 1'b0, 8'h00, 4'h5);
      accV = 8'h3c;
      run(CL_PUSHAF, 1'b0, 8'h00, 4'ha);
      check("save flags", flags, 4'h5);
      accV = 8'h00;
      run(CL_ARITH, 1'b0, 8'h00, 4'ha);
      run(CL_POPAF, 1'b0, 8'h00, 4'h0);
      check("restore flags", flags, 4'h5);
      check("restore acc", accOut, 8'h3c);
      check("restore acc load", alSeen, 1'b1);
      expF = 4'h5;
      $display("test save done");
   endtask : test_save

   task automatic test_bit_range();
      run(CL_BIT_CLR_MEM, 1'b0, 8'h3f, 4'ha);
      check("top addr", rjSeen, 1'b0);
      run(CL_BIT_SET_MEM, 1'b0, 8'h40, 4'ha);
      check("over addr", rjSeen, 1'b1);
      check("over addr wb", wbSeen, 1'b0);
      run(CL_TEST_MEM, 1'b1, 8'h40, 4'ha);
      check("over test rej", rjSeen, 1'b1);
      check("over test skip", skSeen, 1'b0);
      check("over test cyc", cyc, 1);
      run(CL_TEST_MEM, 1'b1, 8'h3f, 4'ha);
      check("top test cyc", cyc, 2);
      check("bit flags", flags, expF);
      $display("test bit range done");
   endtask : test_bit_range

   // save then restore, and call then return, each at the earliest legal spacing
   task automatic test_pairs();
      ccfc_req_t p, q;
      int        gap;
      p          = '0;
      q          = '0;
      p.cls      = CL_PUSHAF;
      p.accIn    = 8'h5a;
      q.cls      = CL_POPAF;
      partner_u.issue_pair(p, q, gap);
      check("pair save gap", gap, 1);
      check("pair restore acc", accOut, 8'h5a);
      check("pair restore flags", flags, expF);
      p          = '0;
      p.cls      = CL_CALL;
      p.pcNext   = 10'h1c6;
      p.pcTarget = 10'h0e4;
      q.cls      = CL_RET;
      partner_u.issue_pair(p, q, gap);
      check("pair call gap", gap, 2);
      check("pair ret pc", pcOut, 10'h1c6);
      check("pair ret sp", sp, 8'h00);
      $display("test pairs done");
   endtask : test_pairs

   // every class but CL_PUSHAF and CL_POPAF with both skip outcomes; masked flag bits are flipped each time
   task automatic test_flag_table();
      bit two, skp, wr;
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 31; i++) begin
            c = ccfc_class_t'(i);
            if (c == CL_PUSHAF || c == CL_POPAF) continue;
            two = c inside {CL_GOTO, CL_CALL, CL_IDXM, CL_PCADD, CL_RET, CL_RETI};
            skp = (c inside {CL_CMP_SKIP, CL_TEST_IO, CL_TEST_MEM, CL_INCDEC_SKIP}) && s == 1;
            wr  = !(c inside {CL_COMPARE, CL_CMP_SKIP, CL_TEST_IO, CL_TEST_MEM, CL_GOTO, CL_CALL,
                              CL_RET, CL_RETI, CL_PCADD, CL_ENGINT, CL_DISGINT, CL_SYSCTL});
            af  = expF ^ 4'hf;
            m   = maskOf(c);
            run(c, s[0], 8'h10, af);
            expF = (expF & ~m) | (af & m);
            check(c.name(), flags, expF);
            check("cycles", cyc, (two || skp) ? 2 : 1);
            check("skip", skSeen, skp);
            check("write back", wbSeen, wr);
            check("pc load", plSeen, two && c != CL_IDXM);
            check("acc load", alSeen, 1'b0);
         end
      end
      $display("test flag table done");
   endtask : test_flag_table

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      conclude();
   end

   initial begin
      clk_sys = 1'b0;
      reset   = 1'b1;
      accV    = 8'h00;
      pcN     = '0;
      pcT     = '0;
      expF    = 4'h0;
      repeat (16) @(negedge clk_sys);
      check("reset flags", flags, 4'h0);
      check("reset sp", sp, 8'h00);
      reset = 1'b0;
      test_stack();
      test_gie();
      test_save();
      test_bit_range();
      test_pairs();
      test_flag_table();
      conclude();
   end
endmodule : test_cpu_cycle_and_flag_control
